// [hdl/swrl_pkg.sv]
// Shared constants and types of the single-wire identity and command layer.
// Assumes nothing; included by the top module and the CRC generator.
package swrl_pkg;

  // ==========================================================
  // Identity layout
  localparam int ID_BITS   = 64;
  localparam int FAM_BITS  = 8;
  localparam int SER_BITS  = 48;
  localparam int CRC_BITS  = 8;
  localparam int BODY_BITS = FAM_BITS + SER_BITS;   // 56 bits under the CRC
  localparam int CMD_BITS  = 8;
  localparam logic [CRC_BITS-1:0] CRC_RESET = 8'h00;

  // ==========================================================
  // Identity-level command codes
  localparam logic [7:0] CMD_READ    = 8'h33;
  localparam logic [7:0] CMD_MATCH   = 8'h55;
  localparam logic [7:0] CMD_SEARCH  = 8'hF0;
  localparam logic [7:0] CMD_CSEARCH = 8'hEC;
  localparam logic [7:0] CMD_SKIP    = 8'hCC;
  localparam logic [7:0] CMD_OD_SKIP = 8'h3C;
  localparam logic [7:0] CMD_OD_MATCH = 8'h69;
  localparam logic [7:0] CMD_RESUME  = 8'hA5;

  // ==========================================================
  // Linear memory space limits
  localparam logic [15:0] ADR_GP_LO   = 16'h0000;
  localparam logic [15:0] ADR_REG_LO  = 16'h0200;
  localparam logic [15:0] ADR_CAL_LO  = 16'h0240;
  localparam logic [15:0] ADR_RSV_LO  = 16'h0280;
  localparam logic [15:0] ADR_LOG_LO  = 16'h1000;
  localparam logic [15:0] ADR_LOG_HI  = 16'h2FFF;
  localparam logic [15:0] ADR_CNT_LO  = 16'h020C;   // Read-only counter span
  localparam logic [15:0] ADR_CNT_HI  = 16'h020F;
  localparam logic [15:0] ADR_STAT_LO = 16'h0214;
  localparam logic [15:0] ADR_STAT_HI = 16'h0215;
  localparam logic [15:0] ADR_PW_LO   = 16'h0227;   // Password span
  localparam logic [15:0] ADR_PW_HI   = 16'h0236;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    SWRL_ST_INIT   = 3'b000,
    SWRL_ST_WAIT   = 3'b001,
    SWRL_ST_CMD    = 3'b010,
    SWRL_ST_READ   = 3'b011,
    SWRL_ST_MATCH  = 3'b100,
    SWRL_ST_SEARCH = 3'b101,
    SWRL_ST_DONE   = 3'b110,
    SWRL_ST_IDLE   = 3'b111
  } swrl_state_t;

endpackage

// [hdl/swrl_crc8.sv]
// Serial CRC generator for the identity, one bit per shift.
// Assumes clear and shift come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module swrl_crc8
  import swrl_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  input  wire logic                clr,
  input  wire logic                shift,
  input  wire logic                din,
  output logic [swrl_pkg::CRC_BITS-1:0] crc
);
  import swrl_pkg::*;

  logic [CRC_BITS-1:0] crc_q;
  logic [CRC_BITS-1:0] crc_d;
  logic                fb;

  // ==========================================================
  // Next value: reflected shift with taps at 5, 4 and 0
  always_comb begin
    fb    = din ^ crc_q[0];
    crc_d = crc_q;
    if (clr) begin
      crc_d = CRC_RESET;
    end else if (shift) begin
      crc_d = {fb, crc_q[7:5], crc_q[4] ^ fb, crc_q[3] ^ fb,
               crc_q[2:1]};
    end
  end

  // Register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      crc_q <= CRC_RESET;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;
endmodule
`default_nettype wire

// [hdl/swrl_top.sv]
// Identity layer of a single-wire bus slave: identity with CRC, identity
// commands, overdrive switch and memory-space access limits.
// Assumes a bit-level engine on ref_clk that reports each time slot.
//
// Operation
// - Hold 64-bit identity: family code, 48-bit serial, CRC over 56 bits.
// - CRC made by XOR-feedback shift register, polynomial x8+x5+x4+1.
// - CRC shift register cleared to zero before first identity bit.
// - Family code LSB first, then serial; register then holds the CRC.
// - Memory and control commands open only once an identity command ends.
// - Overdrive command finished at standard speed switches to high speed.
// - Every byte moves least significant bit first.
// - Memory regions share one linear space; identity and scratchpad outside.
// - Both register pages are write-blocked during a logging mission.
// - Password registers accept writes but never return stored values.
// - Logging memory, counters and some registers are read-only.
// - Identity commands work from bus power even with battery exhausted.
`timescale 1ns/1ns
`default_nettype none
module swrl_top
  import swrl_pkg::*;
#(
  parameter logic [7:0]  FAMILY_CODE = 8'h5A,          // Arbitrary value
  parameter logic [47:0] SERIAL_NO   = 48'h0123456789AB // Arbitrary value
)
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        bus_reset,
  input  wire logic        reset_std,
  input  wire logic        slot_valid,
  input  wire logic        slot_bit,
  input  wire logic        alarm_flag,
  input  wire logic        battery_ok,
  input  wire logic        mission_active,
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic [15:0] mem_addr,
  output logic             drive_low,
  output logic             overdrive,
  output logic             func_access,
  output logic             id_ready,
  output logic             id_crc_ok,
  output logic             mem_ack,
  output logic             mem_in_space,
  output logic             mem_allow,
  output logic             mem_read_mask
);
  import swrl_pkg::*;

  // ==========================================================
  // Access decode shared by read and write paths
  function automatic logic in_rng(input logic [15:0] a,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  logic [ID_BITS-1:0]  id_body;
  logic [CRC_BITS-1:0] crc_val;
  logic                crc_shift;
  logic                crc_din;

  swrl_state_t         st_q,   st_d;
  logic [6:0]          cnt_q,  cnt_d;
  logic [1:0]          ph_q,   ph_d;
  logic [7:0]          cmd_q,  cmd_d;
  logic [7:0]          idcrc_q, idcrc_d;
  logic                rdy_q,  rdy_d;
  logic                ok_q,   ok_d;
  logic                od_q,   od_d;
  logic                odm_q,  odm_d;
  logic                sel_q,  sel_d;
  logic                drv_q,  drv_d;
  logic                idbit;

  // Identity with stored CRC in the top byte
  assign id_body = {idcrc_q, SERIAL_NO, FAMILY_CODE};
  assign idbit   = id_body[cnt_q[5:0]];

  // CRC fed the identity bits while the identity is checked after reset;
  // the first CRC bit comes straight from the register, which is loaded
  // into the identity on that same edge, and no shift follows bit 63
  assign crc_shift = (st_q == SWRL_ST_INIT) && (cnt_q < 7'(ID_BITS));
  assign crc_din   = (cnt_q == 7'(BODY_BITS)) ? crc_val[0]
                                              : id_body[cnt_q[5:0]];

  swrl_crc8 u_crc (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clr     (1'b0),
    .shift   (crc_shift),
    .din     (crc_din),
    .crc     (crc_val)
  );

  // ==========================================================
  // Identity command sequencer: next values
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    ph_d    = ph_q;
    cmd_d   = cmd_q;
    idcrc_d = idcrc_q;
    rdy_d   = rdy_q;
    ok_d    = ok_q;
    od_d    = od_q;
    odm_d   = odm_q;
    sel_d   = sel_q;
    drv_d   = 1'b0;
    case (st_q)
      SWRL_ST_INIT: begin
        // Family LSB first, then serial, then stored CRC
        cnt_d = cnt_q + 7'd1;
        if (cnt_q == 7'(BODY_BITS)) begin
          idcrc_d = crc_val;
        end
        if (cnt_q == 7'(ID_BITS)) begin
          ok_d  = (crc_val == CRC_RESET);
          rdy_d = 1'b1;
          st_d  = SWRL_ST_WAIT;
          cnt_d = 7'd0;
        end
      end
      SWRL_ST_WAIT, SWRL_ST_DONE, SWRL_ST_IDLE: begin
        // Nothing until a reset pulse           
      end
      SWRL_ST_CMD: begin
        if (slot_valid) begin
          cmd_d = {slot_bit, cmd_q[7:1]};
          cnt_d = cnt_q + 7'd1;
          if (cnt_q == 7'(CMD_BITS - 1)) begin
            cnt_d = 7'd0;
            ph_d  = 2'd0;
            case ({slot_bit, cmd_q[7:1]})
              CMD_READ:     st_d = SWRL_ST_READ;
              CMD_MATCH:    st_d = SWRL_ST_MATCH;
              CMD_OD_MATCH: begin
                st_d  = SWRL_ST_MATCH;
                odm_d = 1'b1;
              end
              CMD_SEARCH:   st_d = SWRL_ST_SEARCH;
              CMD_CSEARCH:  st_d = alarm_flag ? SWRL_ST_SEARCH
                                              : SWRL_ST_IDLE;
              CMD_SKIP: begin
                st_d  = SWRL_ST_DONE;
                sel_d = 1'b0;
              end
              CMD_OD_SKIP: begin
                st_d  = SWRL_ST_DONE;
                sel_d = 1'b0;
                od_d  = 1'b1;
              end
              CMD_RESUME:   st_d = sel_q ? SWRL_ST_DONE : SWRL_ST_IDLE;
              default:      st_d = SWRL_ST_IDLE;
            endcase
          end
        end
      end
      SWRL_ST_READ: begin
        drv_d = ~idbit;
        if (slot_valid) begin
          cnt_d = cnt_q + 7'd1;
          drv_d = ~id_body[6'(cnt_q + 7'd1)];
          if (cnt_q == 7'(ID_BITS - 1)) begin
            st_d  = SWRL_ST_DONE;
            drv_d = 1'b0;
          end
        end
      end
      SWRL_ST_MATCH: begin
        if (slot_valid) begin
          cnt_d = cnt_q + 7'd1;
          if (slot_bit != idbit) begin
            st_d = SWRL_ST_IDLE;
          end else if (cnt_q == 7'(ID_BITS - 1)) begin
            st_d  = SWRL_ST_DONE;
            sel_d = 1'b1;
            if (odm_q) begin
              od_d = 1'b1;
            end
          end
        end
      end
      SWRL_ST_SEARCH: begin
        // Bit, its complement, then the master's choice
        drv_d = (ph_q == 2'd0) ? ~idbit : (ph_q == 2'd1) ? idbit : 1'b0;
        if (slot_valid) begin
          ph_d  = (ph_q == 2'd2) ? 2'd0 : ph_q + 2'd1;
          drv_d = (ph_q == 2'd0) ? idbit : 1'b0;
          if (ph_q == 2'd2) begin
            cnt_d = cnt_q + 7'd1;
            drv_d = ~id_body[6'(cnt_q + 7'd1)];
            if (slot_bit != idbit) begin
              st_d  = SWRL_ST_IDLE;
              drv_d = 1'b0;
            end else if (cnt_q == 7'(ID_BITS - 1)) begin
              st_d  = SWRL_ST_DONE;
              sel_d = 1'b1;
              drv_d = 1'b0;
            end
          end
        end
      end
      default: st_d = SWRL_ST_IDLE;
    endcase
    // A bus reset after the start-up identity check restarts command reception; a long one leaves overdrive
    if (bus_reset && (st_q != SWRL_ST_INIT)) begin
      st_d  = SWRL_ST_CMD;
      cnt_d = 7'd0;
      ph_d  = 2'd0;
      odm_d = od_q;      // At high speed any match command counts as an overdrive match
      drv_d = 1'b0;
      if (reset_std) begin
        od_d  = 1'b0;
        odm_d = 1'b0;
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_q    <= SWRL_ST_INIT;
      cnt_q   <= 7'd0;
      ph_q    <= 2'd0;
      cmd_q   <= 8'h00;
      idcrc_q <= CRC_RESET;
      rdy_q   <= 1'b0;
      ok_q    <= 1'b0;
      od_q    <= 1'b0;
      odm_q   <= 1'b0;
      sel_q   <= 1'b0;
      drv_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      ph_q    <= ph_d;
      cmd_q   <= cmd_d;
      idcrc_q <= idcrc_d;
      rdy_q   <= rdy_d;
      ok_q    <= ok_d;
      od_q    <= od_d;
      odm_q   <= odm_d;
      sel_q   <= sel_d;
      drv_q   <= drv_d;
    end
  end

  // Identity layer ignores battery; function layer needs it
  assign drive_low   = drv_q;
  assign overdrive   = od_q;
  assign id_ready    = rdy_q;
  assign id_crc_ok   = ok_q;
  assign func_access = (st_q == SWRL_ST_DONE) && battery_ok;

  // ==========================================================
  // Memory access limits
  logic ack_q, ack_d;
  logic spc_q, spc_d;
  logic alw_q, alw_d;
  logic msk_q, msk_d;

  always_comb begin
    ack_d = mem_req;
    spc_d = in_rng(mem_addr, ADR_GP_LO, ADR_RSV_LO - 16'h0001) ||
            in_rng(mem_addr, ADR_LOG_LO, ADR_LOG_HI);
    msk_d = in_rng(mem_addr, ADR_PW_LO, ADR_PW_HI);
    alw_d = 1'b0;
    if (mem_req && spc_d && func_access) begin
      if (!mem_write) begin
        alw_d = 1'b1;
      end else if (in_rng(mem_addr, ADR_LOG_LO, ADR_LOG_HI)) begin
        alw_d = 1'b0;
      end else if (in_rng(mem_addr, ADR_REG_LO, ADR_CAL_LO - 16'h0001))
      begin
        alw_d = !mission_active &&
                !in_rng(mem_addr, ADR_CNT_LO, ADR_CNT_HI) &&
                !in_rng(mem_addr, ADR_STAT_LO, ADR_STAT_HI);
      end else begin
        alw_d = 1'b1;
      end
    end
  end

  // Access verdict registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      spc_q <= 1'b0;
      alw_q <= 1'b0;
      msk_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      spc_q <= spc_d;
      alw_q <= alw_d;
      msk_q <= msk_d;
    end
  end

  assign mem_ack       = ack_q;
  assign mem_in_space  = spc_q;
  assign mem_allow     = alw_q;
  assign mem_read_mask = msk_q;
endmodule
`default_nettype wire

// [test/swrl_top_asserts.sv]
// Checker of the identity layer: access verdicts, overdrive, start-up.
// Assumes it is bound to swrl_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module swrl_top_asserts (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        bus_reset,
  input wire logic        reset_std,
  input wire logic        mission_active,
  input wire logic        mem_req,
  input wire logic        mem_write,
  input wire logic [15:0] mem_addr,
  input wire logic        drive_low,
  input wire logic        overdrive,
  input wire logic        func_access,
  input wire logic        id_ready,
  input wire logic        mem_ack,
  input wire logic        mem_in_space,
  input wire logic        mem_allow,
  input wire logic        mem_read_mask
);
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  // Edges since reset release, saturating
  always_comb begin
    cnt_d = cnt_q;
    if (cnt_q != 7'h7F) cnt_d = cnt_q + 7'h01;
  end
  // Count register
  always_ff @(posedge ref_clk) begin
    if (!rstn) cnt_q <= 7'h00;
    else cnt_q <= cnt_d;
  end
  // ==========
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_ack;
    ##1 mem_ack;
  endsequence
  sequence s_wr(lo, hi);
    mem_req && mem_write && mem_addr >= lo && mem_addr <= hi;
  endsequence
  a_ack_follows: assert property (mem_req |-> s_ack)
    else $error("no answer after access request");
  a_ack_cause: assert property (mem_ack |-> $past(mem_req))
    else $error("answer without request");
  a_func_deny: assert property (mem_req && !func_access |=> !mem_allow)
    else $error("access allowed before identity command");
  a_log_ro: assert property (s_wr(16'h1000, 16'h2FFF) |=> !mem_allow)
    else $error("write to logging memory allowed");
  a_mission_lock: assert property (mem_req && mem_write && mission_active &&
    mem_addr inside {[16'h0200:16'h023F]} |=> !mem_allow)
    else $error("register page write allowed in mission");
  a_pw_masked: assert property (mem_req && !mem_write &&
    mem_addr inside {[16'h0227:16'h0236]} |=> mem_read_mask)
    else $error("password read not masked");
  a_space_hole: assert property (mem_req && (mem_addr > 16'h2FFF ||
    mem_addr inside {[16'h0280:16'h0FFF]}) |=> !mem_in_space && !mem_allow)
    else $error("address outside space accepted");
  a_od_leave: assert property (id_ready && bus_reset && reset_std
    |=> !overdrive)
    else $error("overdrive kept after long reset");
  a_cmd_restart: assert property (id_ready && bus_reset
    |=> !func_access && !drive_low)
    else $error("functions open after bus reset");
  a_ready_time: assert property ($rose(id_ready) |-> cnt_q == 7'h41)
    else $error("identity ready at wrong edge");
endmodule
bind swrl_top swrl_top_asserts u_chk (.ref_clk(ref_clk), .rstn(rstn),
  .bus_reset(bus_reset), .reset_std(reset_std), .mem_req(mem_req),
  .mission_active(mission_active), .mem_write(mem_write),
  .mem_addr(mem_addr), .drive_low(drive_low), .overdrive(overdrive),
  .func_access(func_access), .id_ready(id_ready), .mem_ack(mem_ack),
  .mem_in_space(mem_in_space), .mem_allow(mem_allow),
  .mem_read_mask(mem_read_mask));
`default_nettype wire

// [test/swrl_master.sv]
// Bus master model: resets the wire, sends bytes, reads slots.
// Assumes the device answers on drive_low the edge after each slot.
`timescale 1ns/1ns
`default_nettype none
module swrl_master (
  input  wire logic ref_clk,
  input  wire logic drive_low,
  output logic      bus_reset,
  output logic      reset_std,
  output logic      slot_valid,
  output logic      slot_bit
);
  // Idle wire at start
  initial begin
    bus_reset = 1'b0;
    reset_std = 1'b1;
    slot_valid = 1'b0;
    slot_bit = 1'b1;
  end
  // ==========
  // Reset pulse, std picks the long form
  task automatic do_reset(input logic std);
    @(negedge ref_clk);
    bus_reset = 1'b1;
    reset_std = std;
    @(negedge ref_clk);
    bus_reset = 1'b0;
  endtask
  // One slot: master bit wire-ANDed with the device pull-down
  task automatic slot(input logic b, output logic w);
    @(negedge ref_clk);
    slot_valid = 1'b1;
    slot_bit = b & ~drive_low;
    w = slot_bit;
    @(negedge ref_clk);
    // Low half of the slot stands for the recovery time
    slot_valid = 1'b0;
    slot_bit = ~slot_bit; // Stale level not kept
  endtask
  // Byte out, LSB first
  task automatic send_byte(input logic [7:0] v);
    logic w;
    for (int i = 0; i < 8; i++) slot(v[i], w);
  endtask
  // Read slots, LSB first
  task automatic read_bits(input int n, output logic [63:0] v);
    v = 64'h0;
    for (int i = 0; i < n; i++) slot(1'b1, v[i]);
  endtask
endmodule
`default_nettype wire

// [test/swrl_top_tb.sv]
// Testbench of the identity layer with a bus master model.
// Assumes swrl_pkg, swrl_top and swrl_master are compiled first.
`timescale 1ns/1ns
`default_nettype none
module swrl_top_tb;
  import swrl_pkg::*;
  localparam logic [7:0]  FAM = 8'hA3;           // Arbitrary value
  localparam logic [47:0] SER = 48'h00C0FFEE1234; // Arbitrary value
  localparam logic [17:0] TBL [15] = '{18'h00000, 18'h101FF, 18'h30200,
    18'h1023F, 18'h1020C, 18'h10215, 18'h00227, 18'h00236, 18'h30240,
    18'h00280, 18'h00FFF, 18'h11000, 18'h02FFF, 18'h03000, 18'h30210};
  localparam logic [7:0]  CODES [8] = '{CMD_READ, CMD_MATCH, CMD_SEARCH,
    CMD_CSEARCH, CMD_SKIP, CMD_RESUME, CMD_OD_MATCH, CMD_OD_SKIP};
  logic        ref_clk, rstn, alarm_flag, battery_ok, mission_active;
  logic        mem_req, mem_write, bus_reset, reset_std, slot_valid;
  logic        slot_bit, drive_low, overdrive, func_access, id_ready;
  logic        id_crc_ok, mem_ack, mem_in_space, mem_allow, mem_read_mask;
  logic        fa_exp;
  logic [15:0] mem_addr;
  logic [63:0] v, id_exp;
  logic [2:0]  exp_q [$];
  int          bad_count, cmp_count;
  swrl_top #(.FAMILY_CODE(FAM), .SERIAL_NO(SER)) DUT (.ref_clk(ref_clk),
    .rstn(rstn), .bus_reset(bus_reset), .reset_std(reset_std),
    .slot_valid(slot_valid), .slot_bit(slot_bit), .alarm_flag(alarm_flag),
    .battery_ok(battery_ok), .mission_active(mission_active),
    .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
    .drive_low(drive_low), .overdrive(overdrive), .id_ready(id_ready),
    .func_access(func_access), .id_crc_ok(id_crc_ok), .mem_ack(mem_ack),
    .mem_in_space(mem_in_space), .mem_allow(mem_allow),
    .mem_read_mask(mem_read_mask));
  swrl_master M (.ref_clk(ref_clk), .drive_low(drive_low),
    .bus_reset(bus_reset), .reset_std(reset_std),
    .slot_valid(slot_valid), .slot_bit(slot_bit));
  // Clock
  always #10 ref_clk = ~ref_clk;
  // ==========
  // Helpers
  function automatic logic [7:0] crc8(input logic [63:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < n; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
    return c;
  endfunction
  function automatic logic [2:0] verdict(logic [15:0] a, logic w, logic m);
    logic sp, lg, ok;
    lg = a inside {[16'h1000:16'h2FFF]};
    sp = a < 16'h0280 || lg;
    ok = fa_exp && sp && !(w && (lg || (m && a inside {[16'h0200:16'h023F]})
      || a inside {[16'h020C:16'h020F], [16'h0214:16'h0215]}));
    return {sp, ok, a inside {[16'h0227:16'h0236]}};
  endfunction
  task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic mem_op(logic [15:0] a, logic w, logic m);
    @(negedge ref_clk);
    mission_active = m;
    mem_req = 1'b1;
    mem_write = w;
    mem_addr = a;
    exp_q.push_back(verdict(a, w, m));
    @(negedge ref_clk);
    mem_req = 1'b0;
    mem_addr = ~a;
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Verdict watcher, oldest note first
  always @(negedge ref_clk) begin
    if (mem_ack === 1'b1) begin
      if (exp_q.size() == 0) chk("mem queue", 64'h1, 64'h0);
      else chk("mem verdict", 64'(exp_q.pop_front()),
        64'({mem_in_space, mem_allow, mem_read_mask}));
    end
  end
  // Watchdog
  initial begin
    #400000;
    bad_count++;
    give_verdict();
  end
  // ==========
  // Tests
  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    alarm_flag = 1'b0;
    battery_ok = 1'b0;
    mission_active = 1'b0;
    mem_req = 1'b0;
    mem_write = 1'b0;
    mem_addr = 16'h0000;
    fa_exp = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    id_exp = {crc8({8'h00, SER, FAM}, 56), SER, FAM};
    void'($urandom(22));
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (64) @(negedge ref_clk);
    chk("id_ready", 64'h0, 64'(id_ready));
    @(negedge ref_clk);
    chk("id_ready", 64'h1, 64'(id_ready));
    chk("id_crc_ok", 64'h1, 64'(id_crc_ok));
    chk("func_access", 64'h0, 64'(func_access));
    mem_op(16'h0000, 1'b0, 1'b0);
    $display("test start-up done");
    M.do_reset(1'b1);
    M.send_byte(CMD_READ);
    M.read_bits(64, v);
    chk("identity", id_exp, v);
    chk("crc remainder", 64'h0, 64'(crc8(v, 64)));
    chk("func_access", 64'h0, 64'(func_access));
    battery_ok = 1'b1;
    @(negedge ref_clk);
    chk("func_access", 64'h1, 64'(func_access));
    fa_exp = 1'b1;
    foreach (TBL[k]) mem_op(TBL[k][15:0], TBL[k][16], TBL[k][17]);
    repeat (30) mem_op(16'($urandom) & 16'h3FFF, 1'($urandom), 1'($urandom));
    $display("test read and access done");
    M.do_reset(1'b1);
    M.send_byte(8'h00);
    M.read_bits(8, v);
    chk("silent read", 64'hFF, v);
    chk("func_access", 64'h0, 64'(func_access));
    fa_exp = 1'b0;
    mem_op(16'h0010, 1'b1, 1'b0);
    $display("test unknown command done");
    foreach (CODES[k]) begin
      M.do_reset(1'b1);
      M.send_byte(CODES[k]);
      @(negedge ref_clk);
      chk("func_access", 64'(CODES[k] inside {CMD_SKIP, CMD_OD_SKIP}),
        64'(func_access));
      chk("overdrive", 64'(CODES[k] == CMD_OD_SKIP), 64'(overdrive));
    end
    M.do_reset(1'b0);
    M.send_byte(CMD_SKIP);
    @(negedge ref_clk);
    chk("overdrive", 64'h1, 64'(overdrive));
    M.do_reset(1'b1);
    @(negedge ref_clk);
    chk("overdrive", 64'h0, 64'(overdrive));
    // Full overdrive match from standard speed, then resume
    M.do_reset(1'b1);
    M.send_byte(CMD_OD_MATCH);
    for (int i = 0; i < 8; i++) M.send_byte(id_exp[8*i +: 8]);
    @(negedge ref_clk);
    chk("overdrive", 64'h1, 64'(overdrive));
    M.do_reset(1'b0);
    M.send_byte(CMD_RESUME);
    @(negedge ref_clk);
    chk("func_access", 64'h1, 64'(func_access));
    // Conditional search answers only with the alarm raised
    for (int a = 1; a >= 0; a--) begin
      alarm_flag = 1'(a);
      M.do_reset(1'b1);
      M.send_byte(CMD_CSEARCH);
      M.read_bits(2, v);
      chk("search pair", a ? 64'({~id_exp[0], id_exp[0]}) : 64'h3, v);
    end
    $display("test command codes done");
    repeat (4) @(negedge ref_clk);
    chk("pending notes", 64'h0, 64'(exp_q.size()));
    give_verdict();
  end
endmodule
`default_nettype wire
